// File: rtl/pss_pkg.sv
// ==========================================================
// shared constants and types of the program sequencer
package pss_pkg;
    localparam int          PC_W        = 13;          // counter width
    localparam int          AP_W        = 12;          // address pointer width
    localparam int          RET_DEPTH   = 7;           // physical return entries
    localparam logic [12:0] PC_RESET    = 13'h0000;    // counter after reset
    localparam logic [12:0] PC_LAST     = 13'h1fff;    // last address of a segment
    localparam logic [12:0] PC_ONE      = 13'h0001;    // step of one address
    localparam logic        SEG_RESET   = 1'b0;        // segment 0 after reset
    localparam logic [2:0]  SP_RESET    = 3'h7;        // pointer after reset: empty
    localparam logic [2:0]  SP_NONE     = 3'h7;        // value with no entry behind it
    localparam logic [2:0]  SP_ONE      = 3'h1;        // pointer step
    localparam logic [7:0]  REG_IDX_SP  = 8'h01;       // pointer register index
    localparam logic [7:0]  REG_IDX_SEG = 8'h02;       // segment register index
    localparam logic [31:0] RD_NONE     = 32'h00000000; // unmapped read value

    // operations from the instruction decoder
    typedef enum logic [3:0] {
        PSS_STEP, PSS_SKIP, PSS_JUMP, PSS_JUMP_IND, PSS_CALL, PSS_CALL_IND,
        PSS_SYSCALL, PSS_RET, PSS_RET_SKIP, PSS_RET_INT, PSS_TABLE, PSS_PUSH,
        PSS_POP, PSS_INTR
    } pss_cmd_e;

    // one request of the decoder / interrupt controller
    typedef struct packed {
        pss_cmd_e    op;          // operation
        logic        skip_cond;   // skip condition holds
        logic [12:0] target;      // operand field target
        logic [11:0] addr_ptr;    // address pointer register value
        logic [3:0]  int_pending; // 3 remote, 2 timer 2, 1 vsync, 0 serial
        logic [2:0]  bank;        // current bank bits
        logic [4:0]  psw;         // current program status word
    } pss_cmd_s;

    // saved interrupt context
    typedef struct packed {
        logic [2:0] bank;
        logic [4:0] psw;
    } pss_ctx_s;
endpackage

// File: rtl/pss_sequencer.sv
// Overview of operation
// - 13-bit counter plus separate segment selector
// - ordinary instruction advances counter by one
// - jump or call loads operand target
// - skip advances; true condition nops next
// - counter wraps 1FFFH to 0000H, segment kept
// - interrupt forces segment 0, vector 1..4
// - vectors by priority: 4H,3H,2H,1H
// - both resets clear counter and segment
// - system call, or a return to a saved 1, sets segment to 1
// - 4-bit pointer at 01H, top bit zero
// - pointer 7H has no physical entry
// - push decrements pointer, pop increments it
// - seven 14-bit return entries by pointer
// - call or interrupt stores counter plus one
// - return reloads counter from selected entry
// - table read pushes then pops, pointer unchanged
// - interrupt saves bank and status; return restores
// - context stack shifts; third drops oldest
// - context kept across chip-enable reset
// - return-and-skip nops first returned instruction
// - indirect forms use 12-bit address pointer
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
module pss_sequencer (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_rst_i,
    input  wire logic             cmd_valid_i,
    input  wire pss_pkg::pss_cmd_s cmd_i,
    output logic                  cmd_ready_o,
    output logic [12:0]           pc_o,
    output logic                  segment_o,
    output logic                  nop_next_o,
    output logic [11:0]           table_addr_o,
    output logic                  table_strobe_o,
    output logic [11:0]           pop_addr_o,
    output logic                  pop_valid_o,
    output pss_pkg::pss_ctx_s     ctx_restore_o,
    output logic                  ctx_restore_valid_o,
    output logic [3:0]            stack_depth_pointer_o,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o
);
    import pss_pkg::*;

    // ==========================================================
    // state
    typedef enum {PSS_IDLE, PSS_TBL_POP} pss_state_e;

    pss_state_e  state;                  // table read phase
    logic [12:0] pc;                     // program counter
    logic        seg;                    // segment selector
    logic [2:0]  sp;                     // stack depth pointer
    logic [13:0] ret_stack [RET_DEPTH];  // return entries, segment bit on top
    pss_ctx_s    ctx [2];                // interrupt context stack
    logic        skip_nop;               // next instruction is a nop
    logic        ack;                    // bus acknowledge

    // ==========================================================
    // decode
    wire         any_rst   = rst_i | ce_rst_i;          // both resets
    wire         idle      = (state == PSS_IDLE);       // new command possible
    wire         fire      = cmd_valid_i & idle;        // command taken
    wire         tbl_pop   = (state == PSS_TBL_POP);    // second table phase
    wire [12:0]  pc_inc    = pc + PC_ONE;               // wraps inside segment
    wire [13:0]  ret_word  = {seg, pc_inc};             // saved return word
    wire         has_entry = (sp != SP_NONE);           // pointer 7 selects nothing
    wire [13:0]  top_word  = has_entry ? ret_stack[sp] : 14'h0000; // selected entry
    wire [2:0]   sp_dec    = sp - SP_ONE;               // after a push
    wire [2:0]   sp_inc    = sp + SP_ONE;               // after a pop
    wire [12:0]  ap_ext    = {1'b0, cmd_i.addr_ptr};    // 12-bit reach only
    wire         irq_any   = |cmd_i.int_pending;        // a source is pending

    // highest pending source wins, vector is its index plus one
    logic [12:0] vec;
    always_comb begin
        if (cmd_i.int_pending[3]) begin
            vec = 13'h0004;
        end else if (cmd_i.int_pending[2]) begin
            vec = 13'h0003;
        end else if (cmd_i.int_pending[1]) begin
            vec = 13'h0002;
        end else begin
            vec = 13'h0001;
        end
    end

    // ==========================================================
    // next-state of counter, segment and pointer
    logic [12:0] next_pc;
    logic        next_seg;
    logic [2:0]  next_sp;
    logic        push;                   // write an entry
    logic [13:0] push_word;              // entry to write
    logic        next_skip;
    pss_state_e  next_state;

    always_comb begin
        next_pc    = pc;
        next_seg   = seg;
        next_sp    = sp;
        push       = 1'b0;
        push_word  = ret_word;
        next_skip  = skip_nop;
        next_state = state;
        if (tbl_pop) begin
            // give the borrowed level back, resume after the table read
            next_sp    = sp_inc;
            next_pc    = top_word[12:0];
            next_seg   = top_word[13];
            next_state = PSS_IDLE;
        end else if (fire) begin
            next_skip = 1'b0;
            case (cmd_i.op)
                PSS_STEP: begin
                    next_pc = pc_inc;
                end
                PSS_SKIP: begin
                    next_pc   = pc_inc;
                    next_skip = cmd_i.skip_cond;
                end
                PSS_JUMP: begin
                    next_pc = cmd_i.target;
                end
                PSS_JUMP_IND: begin
                    next_pc = ap_ext;
                end
                PSS_CALL, PSS_CALL_IND: begin
                    push    = 1'b1;
                    next_sp = sp_dec;
                    next_pc = (cmd_i.op == PSS_CALL) ? cmd_i.target : ap_ext;
                end
                PSS_SYSCALL: begin
                    push     = 1'b1;
                    next_sp  = sp_dec;
                    next_pc  = cmd_i.target;
                    next_seg = 1'b1;
                end
                PSS_RET, PSS_RET_SKIP, PSS_RET_INT: begin
                    next_pc   = top_word[12:0];
                    next_seg  = top_word[13];
                    next_sp   = sp_inc;
                    next_skip = (cmd_i.op == PSS_RET_SKIP);
                end
                PSS_TABLE: begin
                    push       = 1'b1;
                    next_sp    = sp_dec;
                    next_state = PSS_TBL_POP;
                end
                PSS_PUSH: begin
                    push      = 1'b1;
                    push_word = {1'b0, ap_ext};
                    next_sp   = sp_dec;
                    next_pc   = pc_inc;
                end
                PSS_POP: begin
                    next_sp = sp_inc;
                    next_pc = pc_inc;
                end
                PSS_INTR: begin
                    if (irq_any) begin
                        push     = 1'b1;
                        next_sp  = sp_dec;
                        next_pc  = vec;
                        next_seg = 1'b0;
                    end
                end
                default: begin
                    next_pc = pc_inc;
                end
            endcase
        end
    end

    // ==========================================================
    // counter, segment, skip flag and phase
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            pc       <= PC_RESET;
            seg      <= SEG_RESET;
            skip_nop <= 1'b0;
            state    <= PSS_IDLE;
        end else begin
            pc       <= next_pc;
            seg      <= next_seg;
            skip_nop <= next_skip;
            state    <= next_state;
        end
    end

    // bus write of the pointer, lower priority than the sequencer
    wire sp_sel  = (wb_adr_i == {REG_IDX_SP[5:0], 2'b00});
    wire seg_sel = (wb_adr_i == {REG_IDX_SEG[5:0], 2'b00});
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
    wire sp_wr   = bus_req & wb_we_i & sp_sel & wb_sel_i[0];
    wire seq_sp  = tbl_pop | fire;

    // pointer register
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            sp <= SP_RESET;
        end else if (seq_sp) begin
            sp <= next_sp;
        end else if (sp_wr) begin
            sp <= wb_dat_i[2:0];
        end
    end

    // ==========================================================
    // return entries, one per pointer value 0..6
    genvar gi;
    generate
        for (gi = 0; gi < RET_DEPTH; gi++) begin : g_ret
            always_ff @(posedge clk_i) begin
                if (push && !any_rst && next_sp == 3'(gi)) begin
                    ret_stack[gi] <= push_word;
                end
            end
        end
    endgenerate

    // ==========================================================
    // interrupt context, no reset so it survives chip-enable reset
    wire ctx_save = fire & (cmd_i.op == PSS_INTR) & irq_any & ~any_rst;
    wire ctx_back = fire & (cmd_i.op == PSS_RET_INT) & ~any_rst;

    always_ff @(posedge clk_i) begin
        if (ctx_save) begin
            ctx[1] <= ctx[0];
            ctx[0] <= '{bank: cmd_i.bank, psw: cmd_i.psw};
        end else if (ctx_back) begin
            ctx[0] <= ctx[1];
        end
    end

    // ==========================================================
    // side outputs: restore, table fetch, popped pointer
    always_ff @(posedge clk_i) begin
        if (any_rst) begin
            ctx_restore_o       <= '0;
            ctx_restore_valid_o <= 1'b0;
            table_addr_o        <= '0;
            table_strobe_o      <= 1'b0;
            pop_addr_o          <= '0;
            pop_valid_o         <= 1'b0;
        end else begin
            ctx_restore_valid_o <= ctx_back;
            if (ctx_back) begin
                ctx_restore_o <= ctx[0];
            end
            table_strobe_o <= fire & (cmd_i.op == PSS_TABLE);
            if (fire && cmd_i.op == PSS_TABLE) begin
                table_addr_o <= cmd_i.addr_ptr;
            end
            pop_valid_o <= fire & (cmd_i.op == PSS_POP);
            if (fire && cmd_i.op == PSS_POP) begin
                pop_addr_o <= top_word[11:0];
            end
        end
    end

    // ==========================================================
    // wishbone slave: one wait state, reads of unmapped give zero
    wire [31:0] rd_mux = sp_sel  ? {28'h0000000, 1'b0, sp} :
                         seg_sel ? {31'h00000000, seg} : RD_NONE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack      <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack <= bus_req;
            if (bus_req) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    assign wb_ack_o              = ack;
    assign cmd_ready_o           = idle;
    assign pc_o                  = pc;
    assign segment_o             = seg;
    assign nop_next_o            = skip_nop;
    assign stack_depth_pointer_o = {1'b0, sp};

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (any_rst);

    wire f_step = fire & (cmd_i.op == PSS_STEP);
    wire f_tbl  = fire & (cmd_i.op == PSS_TABLE);

    // a plain step adds one and keeps the segment
    property p_step;
        f_step |=> pc == $past(pc) + PC_ONE && seg == $past(seg);
    endproperty
    a_step: assert property (p_step) else $error("step did not add one");

    property p_wrap;
        f_step && pc == PC_LAST |=> pc == PC_RESET && seg == $past(seg);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap at segment end");

    // a direct jump lands on its operand target
    property p_jump;
        fire && cmd_i.op == PSS_JUMP |=> pc == $past(cmd_i.target);
    endproperty
    a_jump: assert property (p_jump) else $error("jump target missed");

    // indirect call stays in the low range and pushes once
    property p_ind;
        fire && cmd_i.op == PSS_CALL_IND |=> pc[12] == 1'b0 && sp == $past(sp) - SP_ONE;
    endproperty
    a_ind: assert property (p_ind) else $error("indirect call wrong");

    property p_vec;
        fire && cmd_i.op == PSS_INTR && cmd_i.int_pending[3]
            |=> pc == 13'h0004 && seg == 1'b0;
    endproperty
    a_vec: assert property (p_vec) else $error("top source vector wrong");

    // lowest source alone still forces segment 0
    property p_low;
        fire && cmd_i.op == PSS_INTR && cmd_i.int_pending == 4'h1
            |=> pc == 13'h0001 && seg == 1'b0;
    endproperty
    a_low: assert property (p_low) else $error("lowest source vector wrong");

    // a call leaves its return word under the new pointer
    property p_call;
        fire && cmd_i.op == PSS_CALL && sp != 3'h0 |=> ret_stack[sp] == $past(ret_word);
    endproperty
    a_call: assert property (p_call) else $error("return word not stored");

    // segment rises only by system call or by a return to a saved 1
    property p_seg;
        $rose(seg) |-> $past(fire && cmd_i.op == PSS_SYSCALL)
            || $past(fire && top_word[13] && (cmd_i.op == PSS_RET
                || cmd_i.op == PSS_RET_SKIP || cmd_i.op == PSS_RET_INT));
    endproperty
    a_seg: assert property (p_seg) else $error("segment set without system call");

    // return and skip reloads and marks the next fetch
    property p_ret;
        fire && cmd_i.op == PSS_RET_SKIP |=> nop_next_o && pc == $past(top_word[12:0]);
    endproperty
    a_ret: assert property (p_ret) else $error("return and skip wrong");

    sequence s_tbl_start;
        f_tbl ##1 !cmd_ready_o;
    endsequence
    property p_tbl;
        s_tbl_start |=> sp == $past(sp, 2) && cmd_ready_o;
    endproperty
    a_tbl: assert property (p_tbl) else $error("table read moved pointer");

    // pointer reads always show a zero top bit
    property p_top;
        wb_ack_o |-> wb_dat_o[31:3] == 29'h00000000 || !$past(sp_sel);
    endproperty
    a_top: assert property (p_top) else $error("pointer top bit not zero");

    // either reset clears counter and segment
    property p_rst;
        @(posedge clk_i) disable iff (1'b0) any_rst |=> pc == PC_RESET && !seg;
    endproperty
    a_rst: assert property (p_rst) else $error("reset did not clear counter");
endmodule

// File: bench/pss_decoder_model.sv
`timescale 1ns/100ps
// ==========================================================
// decoder model: issues one request and holds it until taken
module pss_decoder_model (
    input  wire logic         clk_i,
    input  wire logic         cmd_ready_i,
    output logic              cmd_valid_o,
    output pss_pkg::pss_cmd_s cmd_o
);
    import pss_pkg::*;

    // idle until the first request
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end

    // ==========================================================
    // request held until the edge that sees ready; ok low on hang
    task automatic send(input pss_cmd_s c, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (cmd_ready_i === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        cmd_valid_o <= 1'b0;
        cmd_o       <= pss_cmd_s'(~c);  // released lines show no stale value
    endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
// ==========================================================
// self-checking bench of the program sequencer
module testbench;
    import pss_pkg::*;

    logic        clk = 1'b0;     // core clock
    logic        rst;            // power-on reset
    logic        ce_rst;         // chip-enable reset
    logic        cmd_valid;      // request valid
    pss_cmd_s    cmd;            // request
    logic        cmd_ready;
    logic [12:0] pc;
    logic        seg;
    logic        nop_next;
    logic [11:0] table_addr;
    logic        table_strobe;
    logic [11:0] pop_addr;
    logic        pop_valid;
    pss_ctx_s    ctx;
    logic        ctx_valid;
    logic [3:0]  sp;
    logic        cyc;            // bus master signals
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [31:0] rd;             // last read data
    int          err_total  = 0;
    int          num_checks = 0;

    // half-period toggle, 4 ns period
    always #2 clk = ~clk;

    pss_decoder_model i_dec (
        .clk_i       (clk),
        .cmd_ready_i (cmd_ready),
        .cmd_valid_o (cmd_valid),
        .cmd_o       (cmd)
    );

    pss_sequencer i_dut (
        .clk_i                 (clk),
        .rst_i                 (rst),
        .ce_rst_i              (ce_rst),
        .cmd_valid_i           (cmd_valid),
        .cmd_i                 (cmd),
        .cmd_ready_o           (cmd_ready),
        .pc_o                  (pc),
        .segment_o             (seg),
        .nop_next_o            (nop_next),
        .table_addr_o          (table_addr),
        .table_strobe_o        (table_strobe),
        .pop_addr_o            (pop_addr),
        .pop_valid_o           (pop_valid),
        .ctx_restore_o         (ctx),
        .ctx_restore_valid_o   (ctx_valid),
        .stack_depth_pointer_o (sp),
        .wb_cyc_i              (cyc),
        .wb_stb_i              (stb),
        .wb_we_i               (we),
        .wb_adr_i              (adr),
        .wb_sel_i              (sel),
        .wb_dat_i              (wdat),
        .wb_dat_o              (rdat),
        .wb_ack_o              (ack)
    );

    // ==========================================================
    // verdict and end of run
    task automatic print_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // value compare, four-state exact
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // counter, segment and pointer together
    task automatic st(input logic [12:0] p, input logic s, input logic [3:0] d);
        chk(32'(pc), 32'(p), "pc");
        chk(32'(seg), 32'(s), "segment");
        chk(32'(sp), 32'(d), "pointer");
    endtask

    // one request; returns once its results have settled
    task automatic issue(input pss_cmd_e op, input logic [12:0] tgt, input logic [3:0] pend,
                         input logic sc, input logic [7:0] cx);
        bit ok;
        i_dec.send(pss_cmd_s'({op, sc, tgt, tgt[11:0], pend, cx}), ok);
        if (!ok) begin
            err_total++;
            print_verdict();
        end
        @(negedge clk);
    endtask

    // classic single bus cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        sel  <= 4'hf;
        we   <= w;
        adr  <= a;
        wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        q = rdat;
        cyc  <= 1'b0;
        stb  <= 1'b0;
        wdat <= ~d;
        if (n == 20) begin
            err_total++;
            print_verdict();
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst    = 1'b1;
        ce_rst = 1'b0;
        cyc    = 1'b0;
        stb    = 1'b0;
        we     = 1'b0;
        adr    = 8'h00;
        sel    = 4'hf;
        wdat   = 32'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        st(13'h0000, 1'b0, 4'h7);
        wb(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h7, "pointer read");
        issue(PSS_STEP, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0001, 1'b0, 4'h7);
        issue(PSS_SKIP, 13'h0, 4'h0, 1'b1, 8'h00);
        chk(32'(nop_next), 32'h1, "skip nop");
        issue(PSS_SKIP, 13'h0, 4'h0, 1'b0, 8'h00);
        chk(32'(nop_next), 32'h0, "no skip");
        st(13'h0003, 1'b0, 4'h7);
        issue(PSS_JUMP, 13'h1fff, 4'h0, 1'b0, 8'h00);
        st(13'h1fff, 1'b0, 4'h7);
        issue(PSS_STEP, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0000, 1'b0, 4'h7);
        issue(PSS_CALL, 13'h0100, 4'h0, 1'b0, 8'h00);
        st(13'h0100, 1'b0, 4'h6);
        issue(PSS_RET, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0001, 1'b0, 4'h7);
        issue(PSS_SYSCALL, 13'h0200, 4'h0, 1'b0, 8'h00);
        st(13'h0200, 1'b1, 4'h6);
        wb(1'b1, 8'h08, 32'h0, rd);
        wb(1'b0, 8'h08, 32'h0, rd);
        chk(rd, 32'h1, "segment read only");
        issue(PSS_JUMP, 13'h0300, 4'h0, 1'b0, 8'h00);
        st(13'h0300, 1'b1, 4'h6);
        issue(PSS_RET_SKIP, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0002, 1'b0, 4'h7);
        chk(32'(nop_next), 32'h1, "return skip nop");
        issue(PSS_TABLE, 13'h0abc, 4'h0, 1'b0, 8'h00);
        chk(32'(table_strobe), 32'h1, "table strobe");
        chk(32'(table_addr), 32'habc, "table addr");
        chk(32'(cmd_ready), 32'h0, "table busy");
        @(negedge clk);
        st(13'h0003, 1'b0, 4'h7);
        issue(PSS_PUSH, 13'h0123, 4'h0, 1'b0, 8'h00);
        st(13'h0004, 1'b0, 4'h6);
        issue(PSS_POP, 13'h0, 4'h0, 1'b0, 8'h00);
        chk(32'(pop_valid), 32'h1, "pop valid");
        chk(32'(pop_addr), 32'h123, "pop addr");
        st(13'h0005, 1'b0, 4'h7);
        issue(PSS_JUMP_IND, 13'h1abc, 4'h0, 1'b0, 8'h00);
        st(13'h0abc, 1'b0, 4'h7);
        issue(PSS_CALL_IND, 13'h1def, 4'h0, 1'b0, 8'h00);
        st(13'h0def, 1'b0, 4'h6);
        issue(PSS_RET, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0abd, 1'b0, 4'h7);
        issue(PSS_SYSCALL, 13'h0400, 4'h0, 1'b0, 8'h00);
        // nested sources, highest pending wins each time
        for (int i = 0; i < 4; i++) begin
            issue(PSS_INTR, 13'h0, 4'hf >> i, 1'b0, 8'(8'h21 + 8'h11 * i));
            st(13'(4 - i), 1'b0, 4'(5 - i));
        end
        issue(PSS_INTR, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0001, 1'b0, 4'h2);
        issue(PSS_RET_INT, 13'h0, 4'h0, 1'b0, 8'h00);
        st(13'h0003, 1'b0, 4'h3);
        chk(32'(ctx_valid), 32'h1, "context valid");
        chk(32'(ctx), 32'h54, "context");
        // chip-enable reset keeps the context stack
        @(posedge clk);
        ce_rst <= 1'b1;
        @(posedge clk);
        ce_rst <= 1'b0;
        @(negedge clk);
        st(13'h0000, 1'b0, 4'h7);
        issue(PSS_RET_INT, 13'h0, 4'h0, 1'b0, 8'h00);
        chk(32'(pc), 32'h0, "empty pop");
        chk(32'(ctx), 32'h43, "kept context");
        wb(1'b1, 8'h04, 32'h3, rd);
        wb(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h3, "pointer write");
        wb(1'b1, 8'h04, 32'hf, rd);
        wb(1'b0, 8'h04, 32'h0, rd);
        chk(rd, 32'h7, "pointer top bit");
        wb(1'b0, 8'h10, 32'h0, rd);
        chk(rd, 32'h0, "unmapped read");
        print_verdict();
    end
endmodule
